// >>> design/sst_pkg.sv
// package for the startup self-test and error display block
// assumes a single 10 MHz clock and no software-visible registers
package sst_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ        = 10_000_000;        // ref_clk rate
	localparam int unsigned BLINK_MS      = 250;               // blink half period in ms
	localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS; // cycles per blink half
	localparam int unsigned LAMP_MS       = 100;               // all-lamps phase in ms
	localparam int unsigned LAMP_CYC      = CLK_HZ / 1000 * LAMP_MS;  // cycles of lamp test

	// display codes: two bcd digits plus two point bits
	localparam logic [3:0] DIG_EIGHT      = 4'h8;              // digit eight
	localparam logic [3:0] DIG_ZERO       = 4'h0;              // digit zero
	localparam logic [3:0] DIG_BLANK      = 4'hF;              // blank digit
	localparam logic [3:0] DIG_DASH       = 4'hA;              // dash symbol
	localparam logic [3:0] DIG_RUN        = 4'hB;              // run bars symbol
	localparam logic [3:0] DIG_A          = 4'hC;              // letter a
	localparam logic [3:0] DIG_D          = 4'hD;              // letter d
	localparam logic [3:0] FIRST_ROUTINE  = 4'h9;              // first routine number

	// host commands
	localparam logic [3:0] CMD_CLEAR_DISP = 4'h4;              // control function 4
	localparam logic [3:0] CMD_MOD_QUERY  = 4'h3;              // fault query function 3

	// led bit positions
	localparam int unsigned LED_READY     = 0;                 // green ready
	localparam int unsigned LED_RUN       = 1;                 // run
	localparam int unsigned LED_STOP_OUT  = 2;                 // outputs disabled
	localparam int unsigned LED_CTRL      = 3;                 // controller fault
	localparam int unsigned LED_REMOTE    = 4;                 // remote segment fault
	localparam int unsigned LED_LOCAL     = 5;                 // local segment fault
	localparam int unsigned LED_MODULE    = 6;                 // module fault
	localparam int unsigned LED_W         = 7;                 // led count

	typedef enum logic [3:0] {
		SST_LAMP  = 4'b0000,                                   // all lamps on
		SST_TEST  = 4'b0001,                                   // numbered routines
		SST_INIT  = 4'b0010,                                   // general init
		SST_STOP  = 4'b0011,                                   // bus stopped
		SST_ADDR  = 4'b0100,                                   // addressing
		SST_RUN   = 4'b0101,                                   // bus running
		SST_FAIL  = 4'b0110                                    // self-test failure
	} sst_state_t;
endpackage

// >>> design/sst_disp_if.sv
// interface carrying display request from sequencer to blink driver
// assumes both ends on ref_clk
`timescale 1ns/1ps
interface sst_disp_if;
	logic [9:0] code;      // hi digit, lo digit, two points
	logic [9:0] alt_code;  // alternate code while blinking
	logic       blink;     // blink request
	logic       alt_en;    // alternate between code and alt_code
	logic [9:0] shown;     // code actually lit
	modport seq (output code, output alt_code, output blink, output alt_en, input shown);
	modport drv (input code, input alt_code, input blink, input alt_en, output shown);
endinterface

// >>> design/sst_blink.sv
// blink driver: gates or alternates the display code on a slow enable
// assumes the sequencer holds its request steady between changes
`timescale 1ns/1ps
module sst_blink #(
	parameter int unsigned HALF_CYC = sst_pkg::BLINK_CYC  // cycles per blink half
) (
	input  wire logic ref_clk,  // system clock
	input  wire logic rst_b,    // async reset, active low
	sst_disp_if.drv   disp      // display request and result
);
	typedef struct packed {
		logic [31:0] cnt;   // divider count
		logic        phase; // blink phase
		logic [9:0]  shown; // lit code
	} sst_blink_t;

	sst_blink_t s_r;    // state
	sst_blink_t s_nxt;  // next state

	////////////////////////////////////////////////////////////////////////
	// divider and phase, then choice of code
	always_comb begin
		s_nxt = s_r;
		if (s_r.cnt >= HALF_CYC - 1) begin  // half period over
			s_nxt.cnt   = '0;
			s_nxt.phase = ~s_r.phase;
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h0000_0001;
		end
		if (!disp.blink) begin  // steady display
			s_nxt.shown = disp.code;
		end else if (disp.alt_en) begin  // detail alternates with number
			s_nxt.shown = s_r.phase ? disp.alt_code : disp.code; // R8
		end else begin  // on and off
			s_nxt.shown = s_r.phase ? {sst_pkg::DIG_BLANK, sst_pkg::DIG_BLANK, 2'b00} : disp.code; // R7
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign disp.shown = s_r.shown;

	// blinking without detail must blank the display the cycle after the blank half begins
	blink_moves_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
		(disp.blink && !disp.alt_en && s_r.phase && s_r.cnt == 0) |=> s_r.shown[9:6] == sst_pkg::DIG_BLANK)
		else $error("blink did not blank display");
endmodule

// >>> design/sst_selftest.sv
// startup self-test sequencer with front-panel error display
// assumes test results, host commands and bus events arrive as one-cycle
// synchronous pulses or levels on ref_clk; one clock, one reset
//
// Notes on behaviour
// R1 - routines run after reset, counting down displayed
// R2 - startup: all lamps on, shows 8.8.
// R3 - routines 9 to 6 shown first
// R4 - routines 5 to 1 shown next
// R5 - general initialisation shows 00
// R6 - success: ready only, stop/run/ad/code shown; code also lights the outputs-disabled led while not running
// R7 - routine failure makes display blink
// R8 - fault detail alternates with routine number
// R9 - red led selects fault, display classifies
// R10 - non-module faults stop bus, run off
// R11 - host avoids bus addresses while stopped
// R12 - automatic mode restarts bus after reset
// R13 - host resets board only in plc stop
// R14 - no data refresh during self-test
// R15 - controlled mode stays out of run
// R16 - reset discards all host parameters
// R17 - controlled start by address block or card
// R18 - no data refresh while addressing
// R19 - clear display or fault query clears module
// R20 - reconfiguration request reinitialises bus while running
// R21 - monitor bus reset forces outputs zero
// R22 - diagnostic word mirrors leds, one active
// R23 - failure halts sequencer until next reset
`timescale 1ns/1ps
module sst_selftest #(
	parameter int unsigned LAMP_CYC = sst_pkg::LAMP_CYC,  // lamp test length
	parameter int unsigned HALF_CYC = sst_pkg::BLINK_CYC  // blink half period
) (
	input  wire logic        ref_clk,          // system clock
	input  wire logic        rst_b,            // async reset, active low
	input  wire logic        auto_start,       // 1 automatic, 0 controlled start
	input  wire logic        test_done,        // current routine finished, pulse
	input  wire logic        test_fail,        // current routine failed, pulse
	input  wire logic        fail_detail_vld,  // fault detail present with fail
	input  wire logic [7:0]  fail_detail,      // fault detail as two digits
	input  wire logic        init_done,        // general init finished, pulse
	input  wire logic        addr_invalid,     // invalid address setting, level
	input  wire logic        start_req,        // address block or card start, pulse
	input  wire logic        addr_done,        // addressing finished, pulse
	input  wire logic        cmd_vld,          // host command strobe
	input  wire logic [3:0]  cmd_func,         // host command function
	input  wire logic        fault_vld,        // bus fault strobe
	input  wire logic [2:0]  fault_kind,       // one-hot: remote, local, ctrl
	input  wire logic        module_fault,     // module fault strobe
	input  wire logic [7:0]  fault_code,       // fault code for display
	input  wire logic        reconfig_req,     // terminal pushbutton, pulse
	input  wire logic        mon_bus_reset,    // monitor bus reset, pulse
	input  wire logic [15:0] out_data,         // host output word
	input  wire logic [15:0] bus_in_data,      // bus input word
	output logic [9:0]       disp_code,        // digits and points shown
	output logic [6:0]       led,              // front panel leds
	output logic [15:0]      diag_word,        // diagnostic bits to host
	output logic [15:0]      bus_out_r,        // outputs onto bus
	output logic [15:0]      host_in_r,        // inputs toward host
	output logic             bus_cycle_r,      // bus data cycle running
	output logic             params_clr_r      // discard host parameters, pulse
);
	typedef struct packed {
		sst_pkg::sst_state_t st;       // sequencer state
		logic [31:0]         cnt;      // lamp test counter
		logic [3:0]          routine;  // running routine number
		logic [7:0]          detail;   // captured fault detail
		logic                det_vld;  // detail present
		logic [6:0]          led;      // leds
		logic [7:0]          code;     // fault code shown
		logic                code_vld; // fault code pending
		logic [15:0]         bus_out;  // bus outputs
		logic [15:0]         host_in;  // host inputs
		logic                cycle;    // bus cycle
		logic                pclr;     // parameter clear pulse
		logic                first;    // first cycle after reset
	} sst_main_t;

	sst_main_t  s_r;    // state
	sst_main_t  s_nxt;  // next state
	sst_disp_if disp(); // link to blink driver

	////////////////////////////////////////////////////////////////////////
	// display request toward blink driver
	always_comb begin
		disp.blink    = (s_r.st == sst_pkg::SST_FAIL);  // R7
		disp.alt_en   = s_r.det_vld;                    // R8
		disp.alt_code = {s_r.detail, 2'b00};
		case (s_r.st)
			sst_pkg::SST_LAMP: disp.code = {sst_pkg::DIG_EIGHT, sst_pkg::DIG_EIGHT, 2'b11}; // R2
			sst_pkg::SST_TEST,
			sst_pkg::SST_FAIL: disp.code = {sst_pkg::DIG_BLANK, s_r.routine, 2'b00}; // R1
			sst_pkg::SST_INIT: disp.code = {sst_pkg::DIG_ZERO, sst_pkg::DIG_ZERO, 2'b00}; // R5
			default: begin  // after startup
				if (s_r.code_vld) begin  // fault classified on display
					disp.code = {s_r.code, 2'b00}; // R9
				end else if (addr_invalid) begin
					disp.code = {sst_pkg::DIG_A, sst_pkg::DIG_D, 2'b00}; // R6
				end else if (s_r.st == sst_pkg::SST_RUN) begin
					disp.code = {sst_pkg::DIG_RUN, sst_pkg::DIG_RUN, 2'b00}; // R6
				end else begin
					disp.code = {sst_pkg::DIG_DASH, sst_pkg::DIG_DASH, 2'b00}; // R6
				end
			end
		endcase
	end

	sst_blink #(
		.HALF_CYC (HALF_CYC)
	) sst_blink_i (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.disp    (disp.drv)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb begin
		s_nxt      = s_r;
		s_nxt.pclr = 1'b0;
		s_nxt.first = 1'b0;
		if (s_r.first) begin  // params discarded once after reset
			s_nxt.pclr = 1'b1; // R16
		end
		case (s_r.st)
			sst_pkg::SST_LAMP: begin  // lamp test
				s_nxt.led = '1; // R2
				if (s_r.cnt >= LAMP_CYC - 1) begin
					s_nxt.st      = sst_pkg::SST_TEST;
					s_nxt.routine = sst_pkg::FIRST_ROUTINE; // R3
					s_nxt.led     = '0;
				end else begin
					s_nxt.cnt = s_r.cnt + 32'h0000_0001;
				end
			end
			sst_pkg::SST_TEST: begin  // countdown 9..1
				if (test_fail) begin  // halt here
					s_nxt.st      = sst_pkg::SST_FAIL; // R23
					s_nxt.detail  = fail_detail;
					s_nxt.det_vld = fail_detail_vld; // R8
				end else if (test_done) begin
					if (s_r.routine == 4'h1) begin
						s_nxt.st = sst_pkg::SST_INIT; // R5
					end else begin
						s_nxt.routine = s_r.routine - 4'h1; // R4
					end
				end
			end
			sst_pkg::SST_INIT: begin  // general init
				if (init_done) begin
					s_nxt.led = '0;
					s_nxt.led[sst_pkg::LED_READY] = 1'b1; // R6
					if (auto_start) begin  // automatic start
						s_nxt.st = sst_pkg::SST_ADDR; // R12
					end else begin  // controlled: wait for host
						s_nxt.st = sst_pkg::SST_STOP; // R15
					end
				end
			end
			sst_pkg::SST_STOP: begin  // bus stopped
				s_nxt.led[sst_pkg::LED_RUN] = 1'b0;
				if (start_req) begin  // address block or card
					s_nxt.st       = sst_pkg::SST_ADDR; // R17
					s_nxt.code_vld = 1'b0;
					s_nxt.led[6:3] = '0;
				end
			end
			sst_pkg::SST_ADDR: begin  // addressing
				if (addr_done) begin
					s_nxt.st = sst_pkg::SST_RUN;
					s_nxt.led[sst_pkg::LED_RUN] = 1'b1;
				end
			end
			sst_pkg::SST_RUN: begin  // bus running
				if (reconfig_req) begin  // reinit while running
					s_nxt.st = sst_pkg::SST_ADDR; // R20
				end
			end
			sst_pkg::SST_FAIL: begin  // hold until reset
				s_nxt.st = sst_pkg::SST_FAIL; // R23
			end
			default: s_nxt.st = sst_pkg::SST_LAMP;
		endcase

		// faults after startup
		if (s_r.st == sst_pkg::SST_RUN || s_r.st == sst_pkg::SST_ADDR || s_r.st == sst_pkg::SST_STOP) begin
			if (cmd_vld && (cmd_func == sst_pkg::CMD_CLEAR_DISP || cmd_func == sst_pkg::CMD_MOD_QUERY)) begin
				s_nxt.led[sst_pkg::LED_MODULE] = 1'b0; // R19
				s_nxt.code_vld = 1'b0;
			end
			if (module_fault) begin  // cycle keeps running; set wins over clear
				s_nxt.led[sst_pkg::LED_MODULE] = 1'b1; // R10
				s_nxt.code     = fault_code;
				s_nxt.code_vld = 1'b1;
			end
			if (fault_vld) begin  // other faults stop the bus
				s_nxt.st = sst_pkg::SST_STOP; // R10
				s_nxt.led[sst_pkg::LED_RUN]    = 1'b0;
				s_nxt.led[sst_pkg::LED_REMOTE] = fault_kind[2]; // R9
				s_nxt.led[sst_pkg::LED_LOCAL]  = fault_kind[1];
				s_nxt.led[sst_pkg::LED_CTRL]   = fault_kind[0];
				s_nxt.code     = fault_code;
				s_nxt.code_vld = 1'b1;
			end
		end

		// data movement only while running
		s_nxt.cycle = (s_nxt.st == sst_pkg::SST_RUN); // R14 R18
		s_nxt.led[sst_pkg::LED_STOP_OUT] = !s_nxt.cycle;
		if (mon_bus_reset) begin  // monitor reset zeroes outputs
			s_nxt.bus_out = '0; // R21
		end else if (s_r.cycle) begin
			s_nxt.bus_out = out_data;   // R14 R18
			s_nxt.host_in = bus_in_data; // R11
		end
	end

	// state register; reset restarts the whole sequence
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r       <= '0; // R1 R16
			s_r.first <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs from flip-flops
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			disp_code <= '0;
			led       <= '0;
			diag_word <= '0;
		end else begin
			disp_code <= disp.shown;
			led       <= s_r.led;
			diag_word <= {9'h000, s_r.led}; // R22
		end
	end

	assign bus_out_r    = s_r.bus_out;
	assign host_in_r    = s_r.host_in;
	assign bus_cycle_r  = s_r.cycle;
	assign params_clr_r = s_r.pclr;

	////////////////////////////////////////////////////////////////////////
	// checks
	no_refresh_test_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
		(s_r.st == sst_pkg::SST_TEST) |=> $stable(bus_out_r) || $past(mon_bus_reset))
		else $error("outputs changed during self-test");
	fault_stops_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
		(s_r.st == sst_pkg::SST_RUN && fault_vld) |=> !bus_cycle_r && s_r.st == sst_pkg::SST_STOP)
		else $error("bus fault did not stop cycle");
	module_keeps_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
		(s_r.st == sst_pkg::SST_RUN && module_fault && !fault_vld && !reconfig_req) |=> bus_cycle_r)
		else $error("module fault stopped cycle");
	fail_holds_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R23
		(s_r.st == sst_pkg::SST_FAIL) |=> s_r.st == sst_pkg::SST_FAIL && disp.blink)
		else $error("failure state left");
	ctrl_waits_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
		(s_r.st == sst_pkg::SST_STOP && !start_req) |=> s_r.st == sst_pkg::SST_STOP)
		else $error("stop left without start trigger");
	auto_starts_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
		(s_r.st == sst_pkg::SST_INIT && init_done && auto_start) |=> s_r.st == sst_pkg::SST_ADDR)
		else $error("automatic start did not begin addressing");
	countdown_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
		(s_r.st == sst_pkg::SST_TEST && test_done && !test_fail && s_r.routine > 1)
		|=> s_r.routine == $past(s_r.routine) - 4'h1)
		else $error("countdown step wrong");
	mon_reset_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R21
		mon_bus_reset |=> bus_out_r == 16'h0000)
		else $error("monitor reset left outputs set");
	clear_module_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R19
		(s_r.st == sst_pkg::SST_RUN && cmd_vld && cmd_func == sst_pkg::CMD_CLEAR_DISP && !module_fault)
		|=> !s_r.led[sst_pkg::LED_MODULE])
		else $error("clear display ignored");
	lamp_all_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
		(s_r.st == sst_pkg::SST_LAMP && s_r.cnt < LAMP_CYC - 1) |=> s_r.led == 7'h7F)
		else $error("lamp test left a led dark");
	init_zeros_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
		(s_r.st == sst_pkg::SST_INIT && $past(s_r.st) == sst_pkg::SST_INIT) |=> disp_code == 10'h000)
		else $error("init phase not shown as zeros");
	ready_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
		(s_r.st == sst_pkg::SST_INIT && init_done) |=> s_r.led[sst_pkg::LED_READY]
		&& !s_r.led[sst_pkg::LED_RUN] && s_r.led[6:3] == 4'h0)
		else $error("startup end left more than ready lit");
	fail_blinks_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
		(s_r.st == sst_pkg::SST_TEST && test_fail) |=> s_r.st == sst_pkg::SST_FAIL && disp.blink)
		else $error("routine failure did not blink");
	detail_kept_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
		(s_r.st == sst_pkg::SST_TEST && test_fail && fail_detail_vld)
		|=> disp.alt_en && s_r.detail == $past(fail_detail))
		else $error("fault detail not kept");
	ctrl_to_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
		(s_r.st == sst_pkg::SST_INIT && init_done && !auto_start) |=> s_r.st == sst_pkg::SST_STOP && !bus_cycle_r)
		else $error("controlled start left stop");
	params_once_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
		params_clr_r |=> !params_clr_r)
		else $error("parameter discard longer than one cycle");
	addr_no_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R18
		(s_r.st == sst_pkg::SST_ADDR) |=> $stable(host_in_r) && ($stable(bus_out_r) || $past(mon_bus_reset)))
		else $error("data moved while addressing");
	reconfig_readdr_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R20
		(s_r.st == sst_pkg::SST_RUN && reconfig_req && !fault_vld) |=> s_r.st == sst_pkg::SST_ADDR)
		else $error("reconfiguration request ignored");
	diag_mirror_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
		1'b1 |=> diag_word == {9'h000, $past(s_r.led)})
		else $error("diagnostic word does not mirror leds");
endmodule

// >>> tb/sst_host_model.sv
// plc host model: writes the output word and sends host commands
// assumes the shared ref_clk; drives its outputs at the falling edge
`timescale 1ns/1ps
module sst_host_model (
	input  wire logic        ref_clk,     // system clock
	input  wire logic        bus_cycle_r, // bus data cycle running
	output logic      [15:0] out_data,    // output word toward the block
	output logic             cmd_vld,     // command strobe
	output logic      [3:0]  cmd_func     // command function
);
	logic [15:0] word_r = 16'h0000; // word written while running

	// quiet outputs from time zero
	initial begin
		out_data = 16'h0000;
		cmd_vld  = 1'h0;
		cmd_func = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// no access while stopped: the line then toggles, never holds
	always @(negedge ref_clk) begin
		out_data <= bus_cycle_r ? word_r : ~out_data;
	end

	// load the word used while running
	task automatic set_word(input logic [15:0] w);
		word_r = w;
	endtask

	// one-cycle command: clear display or fault query
	task automatic send_cmd(input logic [3:0] f);
		@(negedge ref_clk);
		cmd_vld  <= 1'h1;
		cmd_func <= f;
		@(negedge ref_clk);
		cmd_vld  <= 1'h0;
	endtask
endmodule

// >>> tb/test_startup_selftest_error_display.sv
// self-checking bench for the startup self-test sequencer
// assumes the design package, interface and modules compiled first
`timescale 1ns/1ps
module test_startup_selftest_error_display;
	logic        ref_clk = 1'h0, rst_b = 1'h0, auto_start = 1'h1; // clock, reset, mode
	logic        test_done = 1'h0, test_fail = 1'h0, fail_detail_vld = 1'h0; // results
	logic        init_done = 1'h0, addr_done = 1'h0, start_req = 1'h0; // phase pulses
	logic        fault_vld = 1'h0, module_fault = 1'h0, addr_invalid = 1'h0; // faults
	logic        reconfig_req = 1'h0, mon_bus_reset = 1'h0; // bus events
	logic [7:0]  fail_detail = 8'h00, fault_code = 8'h00; // detail, code
	logic [2:0]  fault_kind = 3'h0; // one-hot kind
	logic [15:0] bus_in_data = 16'h5A5A; // bus inputs
	logic [3:0]  cmd_func; // from host model
	logic        cmd_vld, bus_cycle_r, params_clr_r; // strobes, flags
	logic [15:0] out_data, diag_word, bus_out_r, host_in_r; // data words
	logic [9:0]  disp_code; // display
	logic [6:0]  led; // front leds
	int          err_count = 0, n_compared = 0; // tallies

	////////////////////////////////////////////////////////////////////////
	// 10 MHz clock
	always #50 ref_clk = ~ref_clk;

	// block with short lamp and blink counts
	sst_selftest #(.LAMP_CYC(4), .HALF_CYC(4)) sst_selftest_i (
		.ref_clk, .rst_b, .auto_start, .test_done, .test_fail, .fail_detail_vld, .fail_detail,
		.init_done, .addr_invalid, .start_req, .addr_done, .cmd_vld, .cmd_func, .fault_vld,
		.fault_kind, .module_fault, .fault_code, .reconfig_req, .mon_bus_reset, .out_data,
		.bus_in_data, .disp_code, .led, .diag_word, .bus_out_r, .host_in_r, .bus_cycle_r,
		.params_clr_r
	);

	// plc host on the far side
	sst_host_model sst_host_model_i (.ref_clk, .bus_cycle_r, .out_data, .cmd_vld, .cmd_func);

	////////////////////////////////////////////////////////////////////////
	// compare and tally
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one-cycle pulse from a falling edge
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge ref_clk);
		s = 1'h0;
	endtask

	// let state, leds and display land
	task automatic settle;
		repeat (4) @(negedge ref_clk);
	endtask

	// poll the masked display for a bounded time
	task automatic wait_disp(input string nm, input logic [9:0] m, input logic [9:0] e);
		int i;
		for (i = 0; i < 12 && (disp_code & m) !== e; i++) @(negedge ref_clk);
		chk(nm, {6'h00, e}, {6'h00, disp_code & m});
	endtask

	// reset for six cycles with the chosen mode
	task automatic do_reset(input logic a);
		@(negedge ref_clk);
		rst_b = 1'h0;
		auto_start = a;
		repeat (6) @(negedge ref_clk);
		rst_b = 1'h1;
	endtask

	// routines 9 to 1, init, then addressing in automatic mode
	task automatic countdown(input logic a);
		int n;
		wait_disp("routine", 10'h03C, 10'h024);
		for (n = 8; n >= 1; n--) begin
			pulse(test_done);
			wait_disp("routine", 10'h03C, {4'h0, n[3:0], 2'h0});
		end
		pulse(test_done);
		wait_disp("init", 10'h3FC, 10'h000);
		chk("host_in_r", 16'h0000, host_in_r);
		chk("bus_out_r", 16'h0000, bus_out_r);
		pulse(init_done);
		settle();
		if (a) begin
			pulse(addr_done);
			settle();
		end
	endtask

	// reset then full startup
	task automatic bring_up(input logic a);
		do_reset(a);
		countdown(a);
	endtask

	////////////////////////////////////////////////////////////////////////
	// lamp phase, parameter discard, automatic start into run
	task automatic t_startup;
		int i;
		do_reset(1'h1);
		for (i = 0; i < 3 && params_clr_r !== 1'h1; i++) @(negedge ref_clk);
		chk("params_clr_r", 16'h0001, {15'h0000, params_clr_r});
		wait_disp("lamp", 10'h3FF, 10'h223);
		chk("led", 16'h007F, {9'h000, led});
		countdown(1'h1);
		chk("bus_cycle_r", 16'h0001, {15'h0000, bus_cycle_r});
		chk("led", 16'h0003, {9'h000, led});
		chk("diag_word", 16'h0003, diag_word);
	endtask

	// data copy while running, monitor bus reset
	task automatic t_data;
		int i;
		sst_host_model_i.set_word(16'h1234);
		bus_in_data = 16'hA5C3;
		settle();
		chk("bus_out_r", 16'h1234, bus_out_r);
		chk("host_in_r", 16'hA5C3, host_in_r);
		chk("disp_code", 16'h02EC, {6'h00, disp_code});
		addr_invalid = 1'h1;
		settle();
		chk("disp_code", 16'h0334, {6'h00, disp_code});
		addr_invalid = 1'h0;
		mon_bus_reset = 1'h1;
		@(negedge ref_clk);
		mon_bus_reset = 1'h0;
		for (i = 0; i < 2 && bus_out_r !== 16'h0000; i++) @(negedge ref_clk);
		chk("bus_out_r", 16'h0000, bus_out_r);
	endtask

	// module fault keeps the cycle; both clear commands
	task automatic t_module;
		int k;
		for (k = 0; k < 2; k++) begin
			fault_code = 8'h17;
			pulse(module_fault);
			settle();
			chk("module run", 16'h0003, {14'h0000, led[sst_pkg::LED_MODULE], bus_cycle_r});
			chk("diag module", 16'h0001, {15'h0000, diag_word[sst_pkg::LED_MODULE]});
			chk("disp_code", 16'h005C, {6'h00, disp_code});
			sst_host_model_i.send_cmd(k ? sst_pkg::CMD_MOD_QUERY : sst_pkg::CMD_CLEAR_DISP);
			settle();
			chk("module led", 16'h0000, {15'h0000, led[sst_pkg::LED_MODULE]});
			chk("disp_code", 16'h02EC, {6'h00, disp_code});
		end
	endtask

	// each bus fault kind stops the cycle and lights its led
	task automatic t_fault;
		int k;
		int b;
		for (k = 0; k < 3; k++) begin
			b = (k == 0) ? sst_pkg::LED_CTRL : (k == 1) ? sst_pkg::LED_LOCAL : sst_pkg::LED_REMOTE;
			bring_up(1'h1);
			fault_kind = 3'h1 << k;
			pulse(fault_vld);
			settle();
			chk("run", 16'h0000, {14'h0000, bus_cycle_r, led[sst_pkg::LED_RUN]});
			chk("fault led", 16'h0001, {15'h0000, led[b]});
			chk("diag bit", 16'h0001, {15'h0000, diag_word[b]});
			chk("disp_code", 16'h005C, {6'h00, disp_code});
		end
	endtask

	// controlled start, addressing hold, reconfiguration
	task automatic t_ctrl;
		bring_up(1'h0);
		repeat (20) @(negedge ref_clk);
		chk("run", 16'h0000, {14'h0000, bus_cycle_r, led[sst_pkg::LED_RUN]});
		chk("disp_code", 16'h02A8, {6'h00, disp_code});
		pulse(start_req);
		bus_in_data = 16'h0F0F;
		settle();
		chk("host_in_r", 16'h0000, host_in_r);
		pulse(addr_done);
		settle();
		chk("bus_cycle_r", 16'h0001, {15'h0000, bus_cycle_r});
		chk("host_in_r", 16'h0F0F, host_in_r);
		pulse(reconfig_req);
		settle();
		chk("bus_cycle_r", 16'h0000, {15'h0000, bus_cycle_r});
		bus_in_data = 16'hF00F;
		settle();
		chk("host_in_r", 16'h0F0F, host_in_r);
		pulse(addr_done);
		settle();
		chk("bus_cycle_r", 16'h0001, {15'h0000, bus_cycle_r});
	endtask

	// failure at routine 7 with detail, then halted
	task automatic t_fail;
		do_reset(1'h1);
		wait_disp("routine", 10'h03C, 10'h024);
		test_done = 1'h1; // held over two edges: routines 9 and 8 pass
		repeat (2) @(negedge ref_clk);
		test_done = 1'h0;
		wait_disp("routine", 10'h03C, 10'h01C);
		fail_detail = 8'h42;
		fail_detail_vld = 1'h1;
		pulse(test_fail);
		fail_detail_vld = 1'h0;
		wait_disp("detail", 10'h3FC, 10'h108);
		wait_disp("routine", 10'h03C, 10'h01C);
		pulse(test_done);
		pulse(init_done);
		pulse(addr_done);
		settle();
		wait_disp("routine", 10'h03C, 10'h01C);
		chk("bus_cycle_r", 16'h0000, {15'h0000, bus_cycle_r});
		do_reset(1'h1);
		wait_disp("routine", 10'h03C, 10'h024);
		pulse(test_fail);
		wait_disp("blank", 10'h3FC, 10'h3FC);
	endtask

	////////////////////////////////////////////////////////////////////////
	// counts and verdict
	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		t_startup();
		t_data();
		t_module();
		t_fault();
		t_ctrl();
		t_fail();
		end_of_test();
	end

	// hang guard, well past the expected run length
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		end_of_test();
	end
endmodule
